//--- rtl/tlfdac_pkg.sv
// constants and carrier types for the limit flag and thermal dac map block
// assumes one core clock domain; register accesses arrive already decoded from the serial port
`default_nettype none
package tlfdac_pkg;

  // ==========================================================================
  // register offsets
  localparam logic [7:0] ADDR_STATUS_FIRST   = 8'h00;
  localparam logic [7:0] ADDR_STATUS_SECOND  = 8'h01;
  localparam logic [7:0] ADDR_CTRL_FIRST     = 8'h18;
  localparam logic [7:0] ADDR_CTRL_THIRD     = 8'h1a;
  localparam logic [7:0] ADDR_DAC_SPAN       = 8'h1b;
  localparam logic [7:0] ADDR_MASK_FIRST     = 8'h1d;
  localparam logic [7:0] ADDR_MASK_SECOND    = 8'h1e;
  localparam logic [7:0] ADDR_INT_ZERO_OFF   = 8'h21;
  localparam logic [7:0] ADDR_EXT_ZERO_OFF   = 8'h22;
  localparam logic [7:0] ADDR_VDD_HIGH       = 8'h23;
  localparam logic [7:0] ADDR_VDD_LOW        = 8'h24;
  localparam logic [7:0] ADDR_INT_HIGH       = 8'h25;
  localparam logic [7:0] ADDR_INT_LOW        = 8'h26;
  localparam logic [7:0] ADDR_EXT_HIGH       = 8'h27;
  localparam logic [7:0] ADDR_EXT_LOW        = 8'h28;

  // ==========================================================================
  // reset values
  localparam logic [7:0] RST_ZERO            = 8'h00;
  localparam logic [7:0] RST_ZERO_OFF        = 8'hd8;
  localparam logic [7:0] RST_VDD_HIGH        = 8'hc9;
  localparam logic [7:0] RST_VDD_LOW         = 8'h62;
  localparam logic [7:0] RST_INT_HIGH        = 8'h64;
  localparam logic [7:0] RST_INT_LOW         = 8'hc9;
  localparam logic [7:0] RST_EXT_HIGH        = 8'hff;
  localparam logic [7:0] RST_EXT_LOW         = 8'h00;

  // ==========================================================================
  // field positions
  localparam int BIT_INT_HIGH      = 0;   // status/mask first
  localparam int BIT_INT_LOW       = 1;
  localparam int BIT_EXT_HIGH      = 2;
  localparam int BIT_EXT_LOW       = 3;
  localparam int BIT_EXT_FAULT     = 4;
  localparam int BIT_VDD_RANGE     = 4;   // status/mask second
  localparam int BIT_RES10         = 1;   // control third
  localparam int BIT_THERM_A       = 5;
  localparam int BIT_THERM_B       = 6;
  localparam int BIT_SPAN_A        = 0;   // dac span config
  localparam int BIT_SPAN_B        = 1;
  localparam int BIT_INT_POL_HIGH  = 6;   // control first: 1 = interrupt active high

  localparam logic [7:0] MASK_FIRST_USED  = 8'h1f;
  localparam logic [7:0] MASK_SECOND_USED = 8'h10;

  // dac code limits
  localparam logic [9:0] DAC_FULL_10 = 10'h3ff;
  localparam logic [9:0] DAC_FULL_8  = 10'h0ff;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic       rd;      // one-cycle read strobe
    logic       wr;      // one-cycle write strobe
    logic [7:0] addr;
    logic [7:0] wdata;
  } tlfdac_req_s;

  typedef struct packed {
    logic       load;    // one-cycle pulse: new code valid
    logic [9:0] code;    // right-aligned; 8-bit mode uses [7:0]
  } tlfdac_dac_s;

endpackage
`default_nettype wire

//--- rtl/tlfdac_limit_cmp.sv
// one limit comparator: upper eight result bits against an 8-bit high and low limit
// assumes result and valid come from logic on the same clock
`default_nettype none
module tlfdac_limit_cmp #(
  parameter bit SIGNED_CMP = 1'b1
) (
  input  wire logic [9:0] result,
  input  wire logic       valid,
  input  wire logic [7:0] limit_high,
  input  wire logic [7:0] limit_low,
  output logic            above,
  output logic            below
);

  logic signed [8:0] res_s;
  logic signed [8:0] high_s;
  logic signed [8:0] low_s;

  // ==========================================================================
  // widths differ, so the two fraction bits are dropped before comparing
  always_comb begin
    if (SIGNED_CMP) begin
      res_s  = {result[9], result[9:2]};
      high_s = {limit_high[7], limit_high};
      low_s  = {limit_low[7], limit_low};
    end else begin
      res_s  = {1'b0, result[9:2]};        // supply result is unsigned
      high_s = {1'b0, limit_high};
      low_s  = {1'b0, limit_low};
    end
    above = valid & (res_s > high_s);
    below = valid & (res_s < low_s);
  end

endmodule
`default_nettype wire

//--- rtl/tlfdac_top.sv
// limit flags, interrupt output and thermal dac code mapping
// assumes the serial port decoder delivers one-cycle read/write strobes on core_clk
// and the measurement sequencer delivers results with one-cycle done pulses
//
// Functional notes
// - temperatures are 10-bit two's complement, quarter degree per code
// - internal, external and supply results compared against high and low limits
// - 8-bit limits compared against 10-bit results
// - unmasked out-of-limit results set flags in the two status registers
// - any active flag drives interrupt at the programmed polarity
// - control bits 5 and 6 route internal to dac a, external to dac b
// - thermal dac code reloads on each completed temperature measurement
// - one code is 1 degree at 8 bits, quarter degree at 10 bits
// - resolution defaults to 8 bits; control bit 1 selects 10 bits
// - span config bit 0 doubles dac a span, bit 1 dac b
// - internal zero offset at 21h sets zero-code temperature, reset minus forty
// - zero offset registers are 8 bits, 1 degree resolution
// - dac code saturates at full scale above span top
// - dac code is temperature minus zero-point temperature
// - status registers clear on host read or software reset
// - first status bits: int high, int low, ext high, ext low, sensor fault
// - second status bit 4 flags supply outside its limits
`default_nettype none
module tlfdac_top
  import tlfdac_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire tlfdac_req_s reg_req,
  output tlfdac_dac_s      dac_a,
  output tlfdac_dac_s      dac_b,
  output logic [7:0]       reg_rdata,
  output logic             int_out,
  output logic             dac_a_double_span,
  output logic             dac_b_double_span,
  output logic             dac_res10,
  input  wire logic [9:0]  int_temp,
  input  wire logic        int_temp_done,
  input  wire logic [9:0]  ext_temp,
  input  wire logic        ext_temp_done,
  input  wire logic [9:0]  vdd_result,
  input  wire logic        vdd_done,
  input  wire logic        ext_fault,
  input  wire logic        sw_reset
);

  // ==========================================================================
  // reset release
  logic       rst_meta_b;
  logic       rst_sync_b;

  // release is synchronised so that no flop leaves reset a cycle apart from another
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  // ==========================================================================
  // writable registers
  logic [7:0] ctrl_first,    next_ctrl_first;
  logic [7:0] ctrl_third,    next_ctrl_third;
  logic [7:0] span_cfg,      next_span_cfg;
  logic [7:0] mask_first,    next_mask_first;
  logic [7:0] mask_second,   next_mask_second;
  logic [7:0] int_zero_off,  next_int_zero_off;
  logic [7:0] ext_zero_off,  next_ext_zero_off;
  logic [7:0] vdd_high,      next_vdd_high;
  logic [7:0] vdd_low,       next_vdd_low;
  logic [7:0] int_high,      next_int_high;
  logic [7:0] int_low,       next_int_low;
  logic [7:0] ext_high,      next_ext_high;
  logic [7:0] ext_low,       next_ext_low;

  // write decode; offsets are stored raw, software does the encoding
  always_comb begin
    next_ctrl_first   = ctrl_first;
    next_ctrl_third   = ctrl_third;
    next_span_cfg     = span_cfg;
    next_mask_first   = mask_first;
    next_mask_second  = mask_second;
    next_int_zero_off = int_zero_off;
    next_ext_zero_off = ext_zero_off;
    next_vdd_high     = vdd_high;
    next_vdd_low      = vdd_low;
    next_int_high     = int_high;
    next_int_low      = int_low;
    next_ext_high     = ext_high;
    next_ext_low      = ext_low;
    if (reg_req.wr) begin
      unique case (reg_req.addr)
        ADDR_CTRL_FIRST:   next_ctrl_first   = reg_req.wdata;
        ADDR_CTRL_THIRD:   next_ctrl_third   = reg_req.wdata;
        ADDR_DAC_SPAN:     next_span_cfg     = reg_req.wdata;
        ADDR_MASK_FIRST:   next_mask_first   = reg_req.wdata;
        ADDR_MASK_SECOND:  next_mask_second  = reg_req.wdata;
        ADDR_INT_ZERO_OFF: next_int_zero_off = reg_req.wdata;
        ADDR_EXT_ZERO_OFF: next_ext_zero_off = reg_req.wdata;
        ADDR_VDD_HIGH:     next_vdd_high     = reg_req.wdata;
        ADDR_VDD_LOW:      next_vdd_low      = reg_req.wdata;
        ADDR_INT_HIGH:     next_int_high     = reg_req.wdata;
        ADDR_INT_LOW:      next_int_low      = reg_req.wdata;
        ADDR_EXT_HIGH:     next_ext_high     = reg_req.wdata;
        ADDR_EXT_LOW:      next_ext_low      = reg_req.wdata;
        default:           ;                                    // read-only or unmapped
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ctrl_first   <= RST_ZERO;
      ctrl_third   <= RST_ZERO;
      span_cfg     <= RST_ZERO;
      mask_first   <= RST_ZERO;
      mask_second  <= RST_ZERO;
      int_zero_off <= RST_ZERO_OFF;
      ext_zero_off <= RST_ZERO_OFF;
      vdd_high     <= RST_VDD_HIGH;
      vdd_low      <= RST_VDD_LOW;
      int_high     <= RST_INT_HIGH;
      int_low      <= RST_INT_LOW;
      ext_high     <= RST_EXT_HIGH;
      ext_low      <= RST_EXT_LOW;
    end else begin
      ctrl_first   <= next_ctrl_first;
      ctrl_third   <= next_ctrl_third;
      span_cfg     <= next_span_cfg;
      mask_first   <= next_mask_first;
      mask_second  <= next_mask_second;
      int_zero_off <= next_int_zero_off;
      ext_zero_off <= next_ext_zero_off;
      vdd_high     <= next_vdd_high;
      vdd_low      <= next_vdd_low;
      int_high     <= next_int_high;
      int_low      <= next_int_low;
      ext_high     <= next_ext_high;
      ext_low      <= next_ext_low;
    end
  end

  // ==========================================================================
  // limit comparators
  logic int_above, int_below;
  logic ext_above, ext_below;
  logic vdd_above, vdd_below;

  tlfdac_limit_cmp #(.SIGNED_CMP(1'b1)) u_cmp_int (
    .result     (int_temp),
    .valid      (int_temp_done),
    .limit_high (int_high),
    .limit_low  (int_low),
    .above      (int_above),
    .below      (int_below)
  );

  tlfdac_limit_cmp #(.SIGNED_CMP(1'b1)) u_cmp_ext (
    .result     (ext_temp),
    .valid      (ext_temp_done),
    .limit_high (ext_high),
    .limit_low  (ext_low),
    .above      (ext_above),
    .below      (ext_below)
  );

  tlfdac_limit_cmp #(.SIGNED_CMP(1'b0)) u_cmp_vdd (
    .result     (vdd_result),
    .valid      (vdd_done),
    .limit_high (vdd_high),
    .limit_low  (vdd_low),
    .above      (vdd_above),
    .below      (vdd_below)
  );

  // ==========================================================================
  // sticky status flags and interrupt
  logic [7:0] status_first,  next_status_first;
  logic [7:0] status_second, next_status_second;
  logic [7:0] set_first;
  logic [7:0] set_second;
  logic       clr_first;
  logic       clr_second;
  logic       next_int_out;

  // a set in the clearing cycle survives, so no event is lost to a read
  always_comb begin
    set_first                = 8'h00;
    set_first[BIT_INT_HIGH]  = int_above;
    set_first[BIT_INT_LOW]   = int_below;
    set_first[BIT_EXT_HIGH]  = ext_above;
    set_first[BIT_EXT_LOW]   = ext_below;
    set_first[BIT_EXT_FAULT] = ext_fault;
    set_first                = set_first & ~mask_first & MASK_FIRST_USED;
    set_second                = 8'h00;
    set_second[BIT_VDD_RANGE] = vdd_above | vdd_below;
    set_second                = set_second & ~mask_second & MASK_SECOND_USED;
    clr_first  = sw_reset | (reg_req.rd && reg_req.addr == ADDR_STATUS_FIRST);
    clr_second = sw_reset | (reg_req.rd && reg_req.addr == ADDR_STATUS_SECOND);
    next_status_first  = (clr_first ? 8'h00 : status_first) | set_first;
    next_status_second = (clr_second ? 8'h00 : status_second) | set_second;
    // pin updates on the same edge as the flags, polarity from control first
    next_int_out = ((|next_status_first) | (|next_status_second))
                   ~^ ctrl_first[BIT_INT_POL_HIGH];
  end

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      status_first  <= RST_ZERO;
      status_second <= RST_ZERO;
      int_out       <= 1'b1;    // idle with default active-low polarity
    end else begin
      status_first  <= next_status_first;
      status_second <= next_status_second;
      int_out       <= next_int_out;
    end
  end

  // ==========================================================================
  // read path; answer registered, one cycle after the strobe
  logic [7:0] next_reg_rdata;

  always_comb begin
    next_reg_rdata = reg_rdata;
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        ADDR_STATUS_FIRST:  next_reg_rdata = status_first;
        ADDR_STATUS_SECOND: next_reg_rdata = status_second;
        ADDR_CTRL_FIRST:    next_reg_rdata = ctrl_first;
        ADDR_CTRL_THIRD:    next_reg_rdata = ctrl_third;
        ADDR_DAC_SPAN:      next_reg_rdata = span_cfg;
        ADDR_MASK_FIRST:    next_reg_rdata = mask_first;
        ADDR_MASK_SECOND:   next_reg_rdata = mask_second;
        ADDR_INT_ZERO_OFF:  next_reg_rdata = int_zero_off;
        ADDR_EXT_ZERO_OFF:  next_reg_rdata = ext_zero_off;
        ADDR_VDD_HIGH:      next_reg_rdata = vdd_high;
        ADDR_VDD_LOW:       next_reg_rdata = vdd_low;
        ADDR_INT_HIGH:      next_reg_rdata = int_high;
        ADDR_INT_LOW:       next_reg_rdata = int_low;
        ADDR_EXT_HIGH:      next_reg_rdata = ext_high;
        ADDR_EXT_LOW:       next_reg_rdata = ext_low;
        default:            next_reg_rdata = 8'h00;   // unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      reg_rdata <= RST_ZERO;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

  // ==========================================================================
  // thermal dac mapping
  // temperature is in quarter degrees, offset in whole degrees, so the offset
  // is scaled by four before subtracting; 12 bits cover the worst difference
  function automatic logic [9:0] therm_code(input logic [9:0] temp,
                                           input logic [7:0] zero_off,
                                           input logic       res10);
    logic signed [11:0] diff;
    logic        [9:0]  code;
    diff = $signed({temp[9], temp[9], temp})
         - $signed({zero_off[7], zero_off[7], zero_off, 2'b00});
    if (diff < 0) begin
      code = 10'h000;
    end else if (res10) begin
      code = (diff > $signed({2'b00, DAC_FULL_10})) ? DAC_FULL_10 : diff[9:0];
    end else begin
      // 8-bit mode drops the quarter bits: one code per degree
      code = (diff[11:2] > DAC_FULL_8) ? DAC_FULL_8 : {2'b00, diff[9:2]};
    end
    return code;
  endfunction

  tlfdac_dac_s next_dac_a;
  tlfdac_dac_s next_dac_b;
  logic        next_dac_res10;

  // codes only move when a fresh result arrives, otherwise they hold
  always_comb begin
    next_dac_res10  = ctrl_third[BIT_RES10];
    next_dac_a.load = int_temp_done & ctrl_third[BIT_THERM_A];
    next_dac_b.load = ext_temp_done & ctrl_third[BIT_THERM_B];
    next_dac_a.code = next_dac_a.load ? therm_code(int_temp, int_zero_off, next_dac_res10) : dac_a.code;
    next_dac_b.code = next_dac_b.load ? therm_code(ext_temp, ext_zero_off, next_dac_res10) : dac_b.code;
  end

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      dac_a             <= '0;
      dac_b             <= '0;
      dac_res10         <= 1'b0;
      dac_a_double_span <= 1'b0;
      dac_b_double_span <= 1'b0;
    end else begin
      dac_a             <= next_dac_a;
      dac_b             <= next_dac_b;
      dac_res10         <= next_dac_res10;
      dac_a_double_span <= span_cfg[BIT_SPAN_A];
      dac_b_double_span <= span_cfg[BIT_SPAN_B];
    end
  end

endmodule
`default_nettype wire

//--- tb/tlfdac_host_model.sv
// host side of the register port: single byte writes and reads
// assumes reg_rdata answers one cycle after the read strobe
`default_nettype none
module tlfdac_host_model
  import tlfdac_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic [7:0] reg_rdata,
  output tlfdac_req_s     reg_req
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  // bus cycles
  initial reg_req = '0;
  // lines go to their inverse once released so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge core_clk);
    reg_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge core_clk);
    reg_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hff};
    #1;
    d = reg_rdata;
  endtask
  // offset byte for a zero-point temperature in whole degrees
  function automatic logic [7:0] enc_off(input int deg);
    enc_off = (deg < 0) ? (8'(deg + 128) | 8'h80) : 8'(deg);
  endfunction
  // quarter-degree result to degrees, negatives via the 512 rule
  function automatic real to_deg(input logic [9:0] c);
    to_deg = c[9] ? (real'(c[8:0]) - 512.0) / 4.0 : real'(c) / 4.0;
  endfunction
endmodule
`default_nettype wire

//--- tb/tlfdac_top_props.sv
// assertions on the top ports of the limit flag and thermal dac block
// assumes one clock domain; bound onto every tlfdac_top
`default_nettype none
module tlfdac_top_props
  import tlfdac_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire tlfdac_req_s reg_req,
  input wire tlfdac_dac_s dac_a,
  input wire tlfdac_dac_s dac_b,
  input wire logic [7:0]  reg_rdata,
  input wire logic        int_out,
  input wire logic        dac_a_double_span,
  input wire logic        dac_res10,
  input wire logic        int_temp_done,
  input wire logic        ext_temp_done,
  input wire logic        vdd_done,
  input wire logic        ext_fault,
  input wire logic        sw_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  logic span_wr;
  logic res_wr;
  logic quiet;
  // ====================
  // helper decodes; span and resolution settings land two edges after the write strobe
  assign span_wr = reg_req.wr && (reg_req.addr == ADDR_DAC_SPAN);
  assign res_wr  = reg_req.wr && (reg_req.addr == ADDR_CTRL_THIRD);
  assign quiet   = !int_temp_done && !ext_temp_done && !ext_fault;
  sequence s_rd0;
    reg_req.rd && (reg_req.addr == ADDR_STATUS_FIRST) && quiet;
  endsequence
  // ====================
  // properties
  property p_load_a; dac_a.load |-> $past(int_temp_done); endproperty
  a_load_a: assert property (p_load_a) else $error("dac a load without done");
  property p_load_b; dac_b.load |-> $past(ext_temp_done); endproperty
  a_load_b: assert property (p_load_b) else $error("dac b load without done");
  property p_code8;
    dac_a.load && !dac_res10 && !$past(dac_res10) |-> dac_a.code[9:8] == 2'h0;
  endproperty
  a_code8: assert property (p_code8) else $error("8-bit code too wide");
  property p_hold_a; !dac_a.load |-> $stable(dac_a.code); endproperty
  a_hold_a: assert property (p_hold_a) else $error("dac a code moved");
  // a polarity write reaches the pin one edge after the register, so two edges back
  property p_int_cause;
    $changed(int_out) |-> $past(int_temp_done | ext_temp_done | vdd_done | ext_fault
                                | sw_reset | reg_req.rd | reg_req.wr) || $past(reg_req.wr, 2);
  endproperty
  a_int_cause: assert property (p_int_cause) else $error("int_out moved alone");
  property p_span; $changed(dac_a_double_span) |-> $past(span_wr) || $past(span_wr, 2); endproperty
  a_span: assert property (p_span) else $error("span moved without write");
  property p_res; $changed(dac_res10) |-> $past(res_wr) || $past(res_wr, 2); endproperty
  a_res: assert property (p_res) else $error("resolution moved without write");
  property p_clear; s_rd0 ##1 quiet ##1 s_rd0 |=> reg_rdata == 8'h00; endproperty
  a_clear: assert property (p_clear) else $error("status not cleared by read");
  c_load_a: cover property (dac_a.load);
  c_int_act: cover property ($fell(int_out));
  c_clear: cover property (s_rd0 ##1 quiet ##1 s_rd0);
endmodule
bind tlfdac_top tlfdac_top_props i_props (.core_clk, .rst_b, .reg_req, .dac_a, .dac_b, .reg_rdata,
  .int_out, .dac_a_double_span, .dac_res10, .int_temp_done, .ext_temp_done, .vdd_done, .ext_fault,
  .sw_reset);
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the limit flag and thermal dac block
// assumes the host model drives the register port; bench drives results
`default_nettype none
module tb_top
  import tlfdac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk;
  logic        rst_b;
  logic [4:0]  pulse;
  logic [9:0]  int_temp;
  logic [9:0]  ext_temp;
  logic [9:0]  vdd_result;
  logic [7:0]  reg_rdata;
  logic [7:0]  rd_val;
  logic        int_out;
  logic        span_a;
  logic        span_b;
  logic        dac_res10;
  tlfdac_req_s reg_req;
  tlfdac_dac_s dac_a;
  tlfdac_dac_s dac_b;
  int          fails;
  int          tests_run;
  tlfdac_host_model i_tlfdac_host_model (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_req(reg_req));
  tlfdac_top i_tlfdac_top (.core_clk(core_clk), .rst_b(rst_b), .reg_req(reg_req), .dac_a(dac_a),
    .dac_b(dac_b), .reg_rdata(reg_rdata), .int_out(int_out), .dac_a_double_span(span_a),
    .dac_b_double_span(span_b), .dac_res10(dac_res10), .int_temp(int_temp), .int_temp_done(pulse[0]),
    .ext_temp(ext_temp), .ext_temp_done(pulse[1]), .vdd_result(vdd_result), .vdd_done(pulse[2]),
    .ext_fault(pulse[3]), .sw_reset(pulse[4]));
  // ====================
  // shared tasks
  task automatic give_verdict();
    $display("checks %0d wrong %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [10:0] exp, input logic [10:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    i_tlfdac_host_model.rd(a, rd_val);
    chk($sformatf("reg %h", a), {3'h0, exp}, {3'h0, rd_val});
  endtask
  // channel 0 int, 1 ext, 2 supply, 3 fault, 4 soft reset; result lines inverted after
  task automatic meas(input int ch, input logic [9:0] v);
    @(posedge core_clk);
    int_temp   <= v;
    ext_temp   <= v;
    vdd_result <= v;
    pulse      <= 5'(1 << ch);
    @(posedge core_clk);
    pulse      <= '0;
    int_temp   <= ~v;
    ext_temp   <= ~v;
    vdd_result <= ~v;
    #1;
  endtask
  // ====================
  // scenarios
  task automatic t_regs();
    logic [7:0] a [9] = '{8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h30};
    logic [7:0] e [9] = '{8'hd8, 8'hd8, 8'hc9, 8'h62, 8'h64, 8'hc9, 8'hff, 8'h00, 8'h00};
    chk("res10", 11'h0, {10'h0, dac_res10});
    for (int i = 0; i < 9; i++) rchk(a[i], e[i]);
    i_tlfdac_host_model.wr(ADDR_STATUS_FIRST, 8'hff);
    rchk(ADDR_STATUS_FIRST, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_limits();
    meas(0, 10'h194);
    meas(0, 10'h320);
    meas(1, 10'h004);
    meas(1, 10'h3fc);
    meas(2, 10'h328);
    meas(3, 10'h000);
    chk("int_out", 11'h0, {10'h0, int_out});
    rchk(ADDR_STATUS_FIRST, 8'h1f);
    rchk(ADDR_STATUS_FIRST, 8'h00);
    rchk(ADDR_STATUS_SECOND, 8'h10);
    @(posedge core_clk);
    #1;
    chk("int_out", 11'h1, {10'h0, int_out});
    $display("test limits done");
  endtask
  task automatic t_mask();
    i_tlfdac_host_model.wr(ADDR_MASK_FIRST, 8'h01);
    meas(0, 10'h194);
    rchk(ADDR_STATUS_FIRST, 8'h00);
    i_tlfdac_host_model.wr(ADDR_CTRL_FIRST, 8'h40);
    meas(1, 10'h3fc);
    @(posedge core_clk);
    #1;
    chk("int_out", 11'h1, {10'h0, int_out});
    meas(4, 10'h000);
    @(posedge core_clk);
    #1;
    chk("int_out", 11'h0, {10'h0, int_out});
    rchk(ADDR_STATUS_FIRST, 8'h00);
    i_tlfdac_host_model.wr(ADDR_CTRL_FIRST, 8'h00);
    i_tlfdac_host_model.wr(ADDR_MASK_FIRST, 8'h00);
    $display("test mask done");
  endtask
  task automatic t_dac();
    i_tlfdac_host_model.wr(ADDR_CTRL_THIRD, 8'h60);
    meas(0, 10'h064);
    chk("dac_a", {1'b1, 10'h041}, dac_a);
    // negative result: expected code from the reader's conversion, zero point at minus forty
    meas(0, 10'h39c);
    chk("dac_a", {1'b1, 10'($rtoi(i_tlfdac_host_model.to_deg(10'h39c)) + 40)}, dac_a);
    meas(0, 10'h338);
    chk("dac_a", {1'b1, 10'h000}, dac_a);
    meas(1, 10'h000);
    chk("dac_b", {1'b1, 10'h028}, dac_b);
    i_tlfdac_host_model.wr(ADDR_INT_ZERO_OFF, i_tlfdac_host_model.enc_off(-128));
    meas(0, 10'h1ff);
    chk("dac_a", {1'b1, 10'h0ff}, dac_a);
    i_tlfdac_host_model.wr(ADDR_CTRL_THIRD, 8'h62);
    meas(0, 10'h1ff);
    chk("dac_a", {1'b1, 10'h3ff}, dac_a);
    chk("res10", 11'h1, {10'h0, dac_res10});
    i_tlfdac_host_model.wr(ADDR_INT_ZERO_OFF, 8'hd8);
    meas(0, 10'h064);
    chk("dac_a", {1'b1, 10'h104}, dac_a);
    i_tlfdac_host_model.wr(ADDR_CTRL_THIRD, 8'h40);
    meas(0, 10'h064);
    chk("dac_a", {1'b0, 10'h104}, dac_a);
    i_tlfdac_host_model.wr(ADDR_DAC_SPAN, 8'h01);
    repeat (2) @(posedge core_clk);
    #1;
    chk("span", 11'h2, {9'h0, span_a, span_b});
    i_tlfdac_host_model.wr(ADDR_DAC_SPAN, 8'h02);
    repeat (2) @(posedge core_clk);
    #1;
    chk("span", 11'h1, {9'h0, span_a, span_b});
    $display("test dac done");
  endtask
  // ====================
  // clock, watchdog and main sequence
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    give_verdict();
  end
  initial begin
    fails      = 0;
    tests_run  = 0;
    rst_b      = 1'b0;
    pulse      = '0;
    int_temp   = '0;
    ext_temp   = '0;
    vdd_result = '0;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_regs();
    t_limits();
    t_mask();
    t_dac();
    give_verdict();
  end
endmodule
`default_nettype wire
